//--- rtl/acst_host.sv
// host end: axi4-lite command registers bridged onto the link
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module acst_host
	import acst_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// axi4-lite write address and data
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// link
	acst_link_if.host        link
);
	typedef enum logic [1:0] {LK_IDLE, LK_WAIT} acst_lk_t;

	logic        aw_q, w_q, bvalid_q, rvalid_q;
	logic [3:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic        wr_fire;
	logic        busy_q, req_q;
	logic [16:0] cmd_q;
	logic [7:0]  bw_sh_q, fmt_sh_q;
	logic [7:0]  rd_cap_q;
	logic        ack_s1_q, ack_s2_q, ack_s3_q;
	logic        req_s1_q, req_s2_q, req_s3_q;
	logic        ack_q;
	logic [7:0]  lk_rdata_q;
	acst_lk_t    lk_q;
	logic        lk_wr_q, lk_rd_q;
	logic [5:0]  lk_addr_q;
	logic [7:0]  lk_wdata_q;
	logic [16:0] cmd_d;
	logic [3:0]  rate_sh;
	logic        cfg_ok, rng_ok;

	// ---------------------------------------------------------------
	// axi4-lite write path
	// ---------------------------------------------------------------
	assign s_axi_awready = !aw_q && !bvalid_q;
	assign s_axi_wready  = !w_q && !bvalid_q;
	assign wr_fire       = aw_q && w_q && !bvalid_q;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			aw_q     <= 1'b0;
			w_q      <= 1'b0;
			awaddr_q <= 4'h0;
			wdata_q  <= 32'h00000000;
			wstrb_q  <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr[3:0];
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_q     <= 1'b0;
				w_q      <= 1'b0;
				bvalid_q <= 1'b1;
				if (awaddr_q == CMD_OFS || awaddr_q == STAT_OFS)
					bresp_q <= RESP_OKAY;
				else
					bresp_q <= RESP_SLV;
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// byte lanes merged into the command word
	always_comb
	begin
		cmd_d = cmd_q;
		if (wstrb_q[0])
			cmd_d[7:0] = wdata_q[7:0];
		if (wstrb_q[1])
			cmd_d[15:8] = wdata_q[15:8];
		if (wstrb_q[2])
			cmd_d[16] = wdata_q[16];
	end

	// ---------------------------------------------------------------
	// command issue, shadow of device configuration
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cmd_q    <= 17'h00000;
			req_q    <= 1'b0;
			busy_q   <= 1'b0;
			bw_sh_q  <= BW_RESET;
			fmt_sh_q <= FMT_RESET;
			rd_cap_q <= 8'h00;
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			ack_s3_q <= 1'b0;
		end
		else
		begin
			ack_s1_q <= ack_q;
			ack_s2_q <= ack_s1_q;
			ack_s3_q <= ack_s2_q;
			if (busy_q && ack_s2_q != ack_s3_q)
			begin
				busy_q   <= 1'b0;
				rd_cap_q <= lk_rdata_q;
			end
			// commands while busy are dropped
			else if (wr_fire && awaddr_q == CMD_OFS && !busy_q)
			begin
				cmd_q  <= cmd_d;
				req_q  <= !req_q;
				busy_q <= 1'b1;
				// self-test toggling goes through here
				if (cmd_d[CMD_WR_BIT]
					&& cmd_d[CMD_AD_LSB +: 6] == BW_ADDR)
					bw_sh_q <= cmd_d[7:0];
				if (cmd_d[CMD_WR_BIT]
					&& cmd_d[CMD_AD_LSB +: 6] == FMT_ADDR)
					fmt_sh_q <= cmd_d[7:0];
			end
		end
	end

	assign rate_sh = bw_sh_q[RATE_LSB +: 4];
	assign rng_ok  = fmt_sh_q[RANGE_LSB +: 2] >= RANGE_8G;
	assign cfg_ok  = ((rate_sh >= RATE_100 && rate_sh <= RATE_800)
		|| rate_sh == RATE_3200)
		&& !bw_sh_q[LOWPWR_BIT]
		&& fmt_sh_q[FULL_BIT]
		&& fmt_sh_q[RANGE_LSB +: 2] == RANGE_16G;

	// ---------------------------------------------------------------
	// axi4-lite read path
	// ---------------------------------------------------------------
	assign s_axi_arready = !rvalid_q;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rdata_q  <= 32'h00000000;
			rresp_q  <= RESP_OKAY;
			if (s_axi_araddr[3:0] == CMD_OFS)
				rdata_q <= {15'h0000, cmd_q};
			else if (s_axi_araddr[3:0] == STAT_OFS)
				rdata_q <= {16'h0000, rd_cap_q, 4'h0, fmt_sh_q[ST_BIT],
					rng_ok, cfg_ok, busy_q};
			else
				rresp_q <= RESP_SLV;
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_q <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	// ---------------------------------------------------------------
	// link side, clocked by the link clock
	// ---------------------------------------------------------------
	always_ff @(posedge link.link_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			req_s1_q   <= 1'b0;
			req_s2_q   <= 1'b0;
			req_s3_q   <= 1'b0;
			ack_q      <= 1'b0;
			lk_q       <= LK_IDLE;
			lk_wr_q    <= 1'b0;
			lk_rd_q    <= 1'b0;
			lk_addr_q  <= 6'h00;
			lk_wdata_q <= 8'h00;
			lk_rdata_q <= 8'h00;
		end
		else
		begin
			req_s1_q <= req_q;
			req_s2_q <= req_s1_q;
			lk_wr_q  <= 1'b0;
			lk_rd_q  <= 1'b0;
			case (lk_q)
				LK_IDLE:
				begin
					// cmd_q is stable while the request is pending
					if (req_s2_q != req_s3_q)
					begin
						req_s3_q   <= req_s2_q;
						lk_addr_q  <= cmd_q[CMD_AD_LSB +: 6];
						lk_wdata_q <= cmd_q[7:0];
						lk_wr_q    <= cmd_q[CMD_WR_BIT];
						lk_rd_q    <= !cmd_q[CMD_WR_BIT];
						lk_q       <= LK_WAIT;
					end
				end
				LK_WAIT:
				begin
					// a write is done once its strobe has been taken
					if (lk_wr_q || link.rvalid)
					begin
						if (link.rvalid)
							lk_rdata_q <= link.rdata;
						ack_q <= !ack_q;
						lk_q  <= LK_IDLE;
					end
				end
				default:
					lk_q <= LK_IDLE;
			endcase
		end
	end

	assign link.wr_en = lk_wr_q;
	assign link.rd_en = lk_rd_q;
	assign link.addr  = lk_addr_q;
	assign link.wdata = lk_wdata_q;
endmodule : acst_host

//--- rtl/acst_pkg.sv
// constants and layouts shared by the accelerometer readout link
package acst_pkg;
	// ---------------------------------------------------------------
	// device register map (link addresses)
	// ---------------------------------------------------------------
	localparam int         LA_W       = 6;
	localparam logic [5:0] BW_ADDR    = 6'h2c;
	localparam logic [5:0] FMT_ADDR   = 6'h31;
	localparam logic [5:0] DATA_ADDR  = 6'h32;
	localparam logic [7:0] BW_RESET   = 8'h0a;
	localparam logic [7:0] FMT_RESET  = 8'h00;
	// ---------------------------------------------------------------
	// fields
	// ---------------------------------------------------------------
	localparam int         RATE_LSB   = 0;
	localparam int         LOWPWR_BIT = 4;
	localparam int         ST_BIT     = 7;
	localparam int         FULL_BIT   = 3;
	localparam int         JUST_BIT   = 2;
	localparam int         RANGE_LSB  = 0;
	localparam logic [3:0] RATE_100   = 4'ha;
	localparam logic [3:0] RATE_800   = 4'hd;
	localparam logic [3:0] RATE_1600  = 4'he;
	localparam logic [3:0] RATE_3200  = 4'hf;
	localparam logic [1:0] RANGE_8G   = 2'h2;
	localparam logic [1:0] RANGE_16G  = 2'h3;
	localparam logic [4:0] BASE_BITS  = 5'h0a;
	localparam logic [4:0] WORD_BITS  = 5'h10;
	localparam int         SCALE_UG   = 3900;
	localparam logic signed [15:0] ST_SHIFT = 16'sh0040;
	// ---------------------------------------------------------------
	// controller registers (axi4-lite byte offsets)
	// ---------------------------------------------------------------
	localparam logic [3:0] CMD_OFS    = 4'h0;
	localparam logic [3:0] STAT_OFS   = 4'h4;
	localparam int         CMD_WR_BIT = 16;
	localparam int         CMD_AD_LSB = 8;
	localparam int         ST_BUSY    = 0;
	localparam int         ST_CFG_OK  = 1;
	localparam int         ST_RNG_OK  = 2;
	localparam int         ST_ON      = 3;
	localparam int         ST_RD_LSB  = 8;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLV   = 2'h2;
endpackage : acst_pkg

//--- rtl/acst_link_if.sv
// register link between the host end and the accelerometer end
`timescale 1ns/1ps
interface acst_link_if
(
	input wire logic link_clk
);
	import acst_pkg::*;
	logic            wr_en;
	logic            rd_en;
	logic [LA_W-1:0] addr;
	logic [7:0]      wdata;
	logic [7:0]      rdata;
	logic            rvalid;

	modport dev
	(
		input  link_clk,
		input  wr_en,
		input  rd_en,
		input  addr,
		input  wdata,
		output rdata,
		output rvalid
	);
	modport host
	(
		input  link_clk,
		output wr_en,
		output rd_en,
		output addr,
		output wdata,
		input  rdata,
		input  rvalid
	);
endinterface : acst_link_if

//--- rtl/acst_dev.sv
// accelerometer end: configuration registers and output formatting
`timescale 1ns/1ps
module acst_dev
	import acst_pkg::*;
(
	// link
	acst_link_if.dev                  link,
	input  wire logic                 reset_n,
	// sensing element, link clock domain
	input  wire logic signed [15:0]   accel_x,
	input  wire logic signed [15:0]   accel_y,
	input  wire logic signed [15:0]   accel_z,
	input  wire logic                 sample_valid,
	// state towards the sensing element
	output logic                      st_drive,
	output logic                      low_power,
	output logic [3:0]                rate_code
);
	logic [7:0]  bw_q;
	logic [7:0]  fmt_q;
	logic [15:0] data_q [3];
	logic [7:0]  rdata_q;
	logic        rvalid_q;
	logic [7:0]  rd_d;

	// ---------------------------------------------------------------
	// sample formatting
	// ---------------------------------------------------------------
	function automatic logic [15:0] fmt_word
	(
		input logic signed [15:0] raw,
		input logic [7:0]         fmt,
		input logic [3:0]         rate
	);
		logic [1:0]         rng;
		logic               full;
		logic [4:0]         nb;
		logic signed [15:0] v;
		logic signed [15:0] lim;
		rng  = fmt[RANGE_LSB +: 2];
		full = fmt[FULL_BIT];
		if (full)
		begin
			v  = raw;
			nb = BASE_BITS + {3'h0, rng};
		end
		else
		begin
			v  = raw >>> rng;
			nb = BASE_BITS;
		end
		lim = (16'sh0001 <<< (nb - 5'h01)) - 16'sh0001;
		if (v > lim)
			v = lim;
		else if (v < -lim - 16'sh0001)
			v = -lim - 16'sh0001;
		// top rates lose the lsb in these modes only
		if ((rate == RATE_1600 || rate == RATE_3200)
			&& (full || rng == 2'h0))
			v[0] = 1'b0;
		if (fmt[JUST_BIT])
			fmt_word = v << (WORD_BITS - nb);
		else
			fmt_word = v;
	endfunction : fmt_word

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge link.link_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bw_q  <= BW_RESET;
			fmt_q <= FMT_RESET;
		end
		else if (link.wr_en)
		begin
			if (link.addr == BW_ADDR)
				bw_q <= link.wdata;
			else if (link.addr == FMT_ADDR)
				fmt_q <= link.wdata;
		end
	end

	assign rate_code = bw_q[RATE_LSB +: 4];
	assign low_power = bw_q[LOWPWR_BIT];
	assign st_drive  = fmt_q[ST_BIT];

	// ---------------------------------------------------------------
	// data capture, stimulus added while self-test is on
	// ---------------------------------------------------------------
	always_ff @(posedge link.link_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			data_q[0] <= 16'h0000;
			data_q[1] <= 16'h0000;
			data_q[2] <= 16'h0000;
		end
		else if (sample_valid)
		begin
			data_q[0] <= fmt_word(st_drive ? accel_x + ST_SHIFT : accel_x,
				fmt_q, rate_code);
			data_q[1] <= fmt_word(st_drive ? accel_y + ST_SHIFT : accel_y,
				fmt_q, rate_code);
			data_q[2] <= fmt_word(st_drive ? accel_z + ST_SHIFT : accel_z,
				fmt_q, rate_code);
		end
	end

	// ---------------------------------------------------------------
	// read decode, unmapped reads return zero
	// ---------------------------------------------------------------
	always_comb
	begin
		rd_d = 8'h00;
		if (link.addr == BW_ADDR)
			rd_d = bw_q;
		else if (link.addr == FMT_ADDR)
			rd_d = fmt_q;
		else if (link.addr == DATA_ADDR)
			rd_d = data_q[0][7:0];
		else if (link.addr == DATA_ADDR + 6'h01)
			rd_d = data_q[0][15:8];
		else if (link.addr == DATA_ADDR + 6'h02)
			rd_d = data_q[1][7:0];
		else if (link.addr == DATA_ADDR + 6'h03)
			rd_d = data_q[1][15:8];
		else if (link.addr == DATA_ADDR + 6'h04)
			rd_d = data_q[2][7:0];
		else if (link.addr == DATA_ADDR + 6'h05)
			rd_d = data_q[2][15:8];
	end

	always_ff @(posedge link.link_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= link.rd_en;
			if (link.rd_en)
				rdata_q <= rd_d;
		end
	end

	assign link.rdata  = rdata_q;
	assign link.rvalid = rvalid_q;
endmodule : acst_dev

//--- testbench/acst_link_props.sv
// link-side assertions for the accelerometer readout link
`timescale 1ns/1ps
module acst_link_props
	import acst_pkg::*;
(
	// link
	input wire logic            link_clk,
	input wire logic            reset_n,
	input wire logic            wr_en,
	input wire logic            rd_en,
	input wire logic [LA_W-1:0] addr,
	input wire logic [7:0]      wdata,
	input wire logic [7:0]      rdata,
	input wire logic            rvalid,
	// device state
	input wire logic            st_drive,
	input wire logic            low_power,
	input wire logic [3:0]      rate_code
);
	logic [7:0] fmt_q;
	logic [2:0] lsb_pos;

	// left-justified full-res lsb position by range
	assign lsb_pos = 3'h6 - {1'b0, fmt_q[RANGE_LSB +: 2]};

	default clocking cb @(posedge link_clk);
	endclocking
	default disable iff (!reset_n);

	// ---------------------------------------------------------------
	// format shadow
	// ---------------------------------------------------------------
	always_ff @(posedge link_clk or negedge reset_n)
		if (!reset_n)
			fmt_q <= FMT_RESET;
		else if (wr_en && addr == FMT_ADDR)
			fmt_q <= wdata;

	// ---------------------------------------------------------------
	// sequences
	// ---------------------------------------------------------------
	sequence s_bw_wr;
		wr_en && addr == BW_ADDR;
	endsequence
	sequence s_fmt_wr;
		wr_en && addr == FMT_ADDR;
	endsequence
	sequence s_read;
		rd_en ##1 rvalid;
	endsequence
	sequence s_top_lo;
		rd_en && addr == DATA_ADDR
			&& (rate_code == RATE_1600 || rate_code == RATE_3200);
	endsequence

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	a_read_answer: assert property (rd_en |-> s_read)
		else $error("read strobe not answered next cycle");
	a_rvalid_cause: assert property (rvalid |-> $past(rd_en))
		else $error("read answer without a read strobe");
	a_rate_write: assert property (s_bw_wr
		|=> rate_code == $past(wdata[3:0])
		&& low_power == $past(wdata[LOWPWR_BIT]))
		else $error("bandwidth write not applied");
	a_rate_hold: assert property (!(wr_en && addr == BW_ADDR)
		|=> $stable(rate_code) && $stable(low_power))
		else $error("bandwidth state changed without a write");
	a_st_write: assert property (s_fmt_wr
		|=> st_drive == $past(wdata[ST_BIT]))
		else $error("self-test stimulus does not follow format bit");
	a_st_hold: assert property (!(wr_en && addr == FMT_ADDR)
		|=> $stable(st_drive))
		else $error("self-test stimulus changed without a write");
	a_bw_readback: assert property (rd_en && addr == BW_ADDR
		|=> rdata[4:0] == {$past(low_power), $past(rate_code)})
		else $error("bandwidth readback wrong");
	a_st_readback: assert property (rd_en && addr == FMT_ADDR
		|=> rdata[ST_BIT] == $past(st_drive))
		else $error("self-test bit readback wrong");
	a_top_lsb_zero: assert property (s_top_lo
		##0 !fmt_q[JUST_BIT]
		&& (fmt_q[FULL_BIT] || fmt_q[RANGE_LSB +: 2] == 2'h0)
		|=> rdata[0] == 1'b0)
		else $error("top rate right-justified lsb not zero");
	a_left_lsb_zero: assert property (s_top_lo
		##0 fmt_q[JUST_BIT] && !fmt_q[FULL_BIT]
		&& fmt_q[RANGE_LSB +: 2] == 2'h0
		|=> rdata[6] == 1'b0)
		else $error("top rate left-justified lsb not zero");
	a_full_left_lsb: assert property (s_top_lo
		##0 fmt_q[JUST_BIT] && fmt_q[FULL_BIT]
		|=> rdata[lsb_pos] == 1'b0)
		else $error("top rate full-res left lsb not zero");
endmodule : acst_link_props

//--- testbench/accel_selftest_output_format_bench.sv
// self-checking bench for the accelerometer readout link
`timescale 1ns/1ps
module accel_selftest_output_format_bench;
	import acst_pkg::*;
	logic        clk = 1'b0;
	logic        link_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        st_drive, low_power;
	logic [3:0]  rate_code;
	int          miscompares = 0;
	int          checks = 0;
	// bw, fmt, expected low byte, expected high byte
	localparam logic [31:0] TAB [11] = '{32'h0d0b2901, 32'h0f0b2801,
		32'h0e0f4009, 32'h0f0e8012, 32'h0f04004a, 32'h0d04404a,
		32'h0f032500, 32'h0f002801, 32'h0d8b6901, 32'h0f0c004a,
		32'h0f0d0025};

	always #2.5 clk = ~clk;
	initial #7 forever #32 link_clk = ~link_clk;

	acst_link_if u_acst_link_if (.link_clk(link_clk));
	acst_dev u_acst_dev (.link(u_acst_link_if), .reset_n(reset_n),
		.accel_x(16'sh0129), .accel_y(16'sh0010), .accel_z(-16'sh0020),
		.sample_valid(1'b1), .st_drive(st_drive), .low_power(low_power),
		.rate_code(rate_code));
	acst_host u_acst_host (.clk(clk), .reset_n(reset_n),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.link(u_acst_link_if));
	acst_link_props u_acst_link_props (.link_clk(link_clk),
		.reset_n(reset_n), .wr_en(u_acst_link_if.wr_en),
		.rd_en(u_acst_link_if.rd_en), .addr(u_acst_link_if.addr),
		.wdata(u_acst_link_if.wdata), .rdata(u_acst_link_if.rdata),
		.rvalid(u_acst_link_if.rvalid), .st_drive(st_drive),
		.low_power(low_power), .rate_code(rate_code));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic axi_wr(input logic [31:0] a, d, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge clk);
			if (!aw_ok && awready)
			begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready)
			begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	task automatic link_op(input logic wr, input logic [5:0] a,
		input logic [7:0] d, output logic [31:0] s);
		logic [1:0] r;
		axi_wr({28'h0, CMD_OFS}, {15'h0, wr, 2'h0, a, d}, r);
		s = 32'h1;
		while (s[ST_BUSY])
			axi_rd({28'h0, STAT_OFS}, s, r);
	endtask : link_op

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset_values();
		logic [31:0] s;
		link_op(1'b0, BW_ADDR, 8'h00, s);
		check(s[15:8], BW_RESET);
		link_op(1'b0, FMT_ADDR, 8'h00, s);
		check(s[15:8], FMT_RESET);
	endtask : t_reset_values

	task automatic t_config();
		logic [31:0] s;
		link_op(1'b1, FMT_ADDR, 8'h0b, s);
		for (int c = 0; c < 16; c++)
		begin
			link_op(1'b1, BW_ADDR, {4'h0, c[3:0]}, s);
			check(rate_code, c[3:0]);
			check(s[ST_CFG_OK], (c >= 10 && c <= 13) || c == 15);
		end
		link_op(1'b1, BW_ADDR, 8'h1d, s);
		check({low_power, s[ST_CFG_OK]}, 2'h2);
		link_op(1'b1, FMT_ADDR, 8'h09, s);
		check(s[ST_RNG_OK], 1'b0);
		link_op(1'b1, FMT_ADDR, 8'h0a, s);
		check(s[3:1], 3'h2);
	endtask : t_config

	task automatic rd_word(input logic [5:0] a, output logic [15:0] w);
		logic [31:0] s;
		link_op(1'b0, a, 8'h00, s);
		w[7:0] = s[15:8];
		link_op(1'b0, a + 6'h01, 8'h00, s);
		w[15:8] = s[15:8];
	endtask : rd_word

	task automatic t_self_test();
		logic [31:0] s;
		logic [15:0] off_w [3];
		logic [15:0] on_w;
		link_op(1'b1, BW_ADDR, 8'h0d, s);
		link_op(1'b1, FMT_ADDR, 8'h0b, s);
		// constant inputs, so one sample stands for the average
		for (int k = 0; k < 3; k++)
			rd_word(DATA_ADDR + 6'(2 * k), off_w[k]);
		check(off_w[0], 16'h0129);
		link_op(1'b1, FMT_ADDR, 8'h8b, s);
		check({st_drive, s[3:0]}, 5'h1e);
		repeat (4) @(posedge link_clk);
		for (int k = 0; k < 3; k++)
		begin
			rd_word(DATA_ADDR + 6'(2 * k), on_w);
			check(16'(on_w - off_w[k]), ST_SHIFT);
		end
		link_op(1'b1, FMT_ADDR, 8'h0b, s);
		check({st_drive, s[3:0]}, 5'h06);
	endtask : t_self_test

	task automatic t_format();
		logic [31:0] s;
		logic [15:0] w;
		for (int i = 0; i < 11; i++)
		begin
			link_op(1'b1, BW_ADDR, TAB[i][31:24], s);
			link_op(1'b1, FMT_ADDR, TAB[i][23:16], s);
			repeat (4) @(posedge link_clk);
			rd_word(DATA_ADDR, w);
			check(w[7:0], TAB[i][15:8]);
			check(w[15:8], TAB[i][7:0]);
		end
	endtask : t_format

	task automatic t_axi_map();
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(32'h8, d, r);
		check(r, RESP_SLV);
		check(d, 32'h0);
		axi_wr(32'h8, 32'h1, r);
		check(r, RESP_SLV);
		axi_wr({28'h0, STAT_OFS}, 32'hffff, r);
		check(r, RESP_OKAY);
		axi_rd({28'h0, CMD_OFS}, d, r);
		check(r, RESP_OKAY);
		check(d[16:0], {1'b0, 2'h0, DATA_ADDR + 6'h1, 8'h00});
	endtask : t_axi_map

	// ---------------------------------------------------------------
	// run control
	// ---------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	initial
	begin
		repeat (8) @(posedge link_clk);
		@(posedge clk);
		reset_n <= 1'b1;
		t_reset_values();
		t_config();
		t_self_test();
		t_format();
		t_axi_map();
		test_done();
	end

	initial
	begin
		repeat (60000) @(posedge clk);
		miscompares++;
		test_done();
	end
endmodule : accel_selftest_output_format_bench
